/* pkg/cfg_seq_pkg.sv */
// constants shared by both ends of the passive configuration link
// Functional notes
// - device drops done within 600 ns of request
// - device pulls status low within 600 ns
// - host holds request low at least 2 us
// - status low pulse 268 to 1506 us
// - status released within 1506 us after request
// - unmonitored host waits 1506 us before clocking
// - monitoring host waits 2 us after status
// - device captures data on config_clock rising edge
// - host keeps config_clock within mode limits
// - compressed parallel data held N clocks
// - oscillator init enters user mode 175-437 us
// - user_startup_clock starts four max clock periods later
// - initialization needs 8576 init clock cycles
// - three init sources with frequency limits
// - user_startup_clock only when option enabled
package cfg_seq_pkg;
  localparam int CLK_MHZ          = 40;
  localparam int CF2CD_NS         = 600;
  localparam int CF2CD_CYC        = (CF2CD_NS * CLK_MHZ) / 1000;
  localparam int CFG_LOW_US       = 2;
  localparam int CFG_LOW_CYC      = CFG_LOW_US * CLK_MHZ;
  localparam int STATUS_MIN_US    = 268;
  localparam int STATUS_MIN_CYC   = STATUS_MIN_US * CLK_MHZ;
  localparam int STATUS_MAX_US    = 1506;
  localparam int STATUS_MAX_CYC   = STATUS_MAX_US * CLK_MHZ;
  localparam int ST2CK_US         = 2;
  localparam int ST2CK_CYC        = ST2CK_US * CLK_MHZ;
  localparam int CD2UM_MIN_US     = 175;
  localparam int CD2UM_MIN_CYC    = CD2UM_MIN_US * CLK_MHZ;
  localparam int CD2UM_MAX_US     = 437;
  localparam int CD2UM_MAX_CYC    = CD2UM_MAX_US * CLK_MHZ;
  localparam int INIT_CYCLES      = 8576;
  localparam int CD2CU_PERIODS    = 4;
  localparam int CLK_HALF_DIV     = 3;
  localparam int DATA_W           = 8;
  localparam int CNT_W            = 20;
  localparam logic [1:0] SRC_OSC  = 2'h0;
  localparam logic [1:0] SRC_USER = 2'h1;
  localparam logic [1:0] SRC_CCLK = 2'h2;
endpackage

/* pkg/cfg_link_if.sv */
// interface joining the configuration host and the device
`timescale 1ns/1ps
interface cfg_link_if #(parameter int W = 8);
  logic         request_n;
  logic         status_o;
  logic         status_oe;
  logic         status_ext_low;
  logic         done;
  logic         config_clock;
  logic [W-1:0] data;
  logic         user_mode;
  logic         status_n;
  assign status_n = !(status_oe && !status_o) && !status_ext_low;
  modport device (input request_n, config_clock, data, status_n,
                  output status_o, status_oe, done, user_mode);
  modport host (output request_n, config_clock, data, status_ext_low,
                input status_n, done, user_mode);
endinterface

/* rtl/cfg_fifo.sv */
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module cfg_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  initial if (D < 2 || (1 << AW) != D) $error("depth must be power of two");
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } fifo_s;
  fifo_s st, next_st;
  logic push, pop;
  assign in_ready  = st.cnt != (AW+1)'(D);
  assign out_valid = st.cnt != '0;
  assign out_data  = st.mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

/* rtl/cfg_device.sv */
// device end: status pulse, data capture, done and initialization
`timescale 1ns/1ps
module cfg_device
  import cfg_seq_pkg::*;
#(
  parameter int STREAM_WORDS = 16,
  parameter int STATUS_CYC   = STATUS_MIN_CYC,
  parameter int UM_CYC       = CD2UM_MIN_CYC,
  parameter int INIT_CNT     = INIT_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  cfg_link_if.device             link,
  input  wire logic [1:0]        init_source,
  input  wire logic              user_clk_enable,
  input  wire logic              user_startup_clock,
  output logic [DATA_W-1:0]      word_data,
  output logic                   word_valid,
  input  wire logic              word_ready,
  output logic                   overflow
);
  initial if (STATUS_CYC < 1 || STATUS_CYC >= (1 << CNT_W) || UM_CYC >= (1 << CNT_W)
              || UM_CYC < 1 || STREAM_WORDS < 1)
    $error("device parameters out of range");
  typedef enum logic [4:0] {
    S_RESET  = 5'h01,
    S_STATUS = 5'h02,
    S_LOAD   = 5'h04,
    S_INIT   = 5'h08,
    S_USER   = 5'h10
  } dev_e;
  typedef struct packed {
    dev_e             state;
    logic [2:0]       req_s;
    logic [2:0]       cclk_s;
    logic [2:0]       uclk_s;
    logic [1:0]       stat_s;
    logic [DATA_W-1:0] data_s1;
    logic [DATA_W-1:0] data_s2;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] words;
    logic [CNT_W-1:0] settle;
    logic             status_low;
    logic             done;
    logic             user_mode;
    logic             bad;
    logic             wvalid;
    logic [DATA_W-1:0] wdata;
  } dev_s;
  dev_s st, next_st;
  // user clock ignored for four host clock periods after done
  localparam int CU_WAIT = CD2CU_PERIODS * 2 * CLK_HALF_DIV;
  logic fifo_in_ready, fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic req_low, cclk_rise, uclk_rise, init_tick;
  assign req_low   = !st.req_s[1];
  assign cclk_rise = st.cclk_s[1] && !st.cclk_s[2];
  assign uclk_rise = st.uclk_s[1] && !st.uclk_s[2];
  always_comb begin
    unique case (init_source)
      SRC_USER: init_tick = user_clk_enable ? (uclk_rise && st.settle >= CNT_W'(CU_WAIT))
                                            : 1'b1;
      SRC_CCLK: init_tick = cclk_rise;
      default:  init_tick = 1'b1;
    endcase
  end
  always_comb begin
    next_st = st;
    next_st.req_s  = {st.req_s[1:0], link.request_n};
    next_st.cclk_s = {st.cclk_s[1:0], link.config_clock};
    next_st.uclk_s = {st.uclk_s[1:0], user_startup_clock};
    next_st.stat_s = {st.stat_s[0], link.status_n};
    next_st.data_s1 = link.data;
    next_st.data_s2 = st.data_s1;
    next_st.wvalid = 1'b0;
    next_st.cnt = st.cnt + 1'b1;
    if (req_low) begin
      next_st.state      = S_STATUS;
      next_st.done       = 1'b0;
      next_st.status_low = 1'b1;
      next_st.user_mode  = 1'b0;
      next_st.cnt        = '0;
      next_st.words      = '0;
      next_st.settle     = '0;
      next_st.bad        = 1'b0;
    end else begin
      unique case (st.state)
        S_RESET: begin
          next_st.state = S_STATUS;
          next_st.status_low = 1'b1;
          next_st.cnt = '0;
        end
        S_STATUS: begin
          if (st.cnt >= CNT_W'(STATUS_CYC - 1)) begin
            next_st.status_low = 1'b0;
            if (st.stat_s[1]) begin
              next_st.state = S_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (cclk_rise) begin
            next_st.wvalid = 1'b1;
            next_st.wdata  = st.data_s2;
            next_st.words  = st.words + 1'b1;
            if (!fifo_in_ready) begin
              next_st.bad = 1'b1;
            end
            if (st.words == CNT_W'(STREAM_WORDS - 1) && !st.bad && fifo_in_ready) begin
              next_st.done  = 1'b1;
              next_st.state = S_INIT;
              next_st.cnt   = '0;
              next_st.settle = '0;
            end
          end
        end
        S_INIT: begin
          next_st.cnt = st.cnt + CNT_W'(init_tick);
          if (st.settle < CNT_W'(CU_WAIT)) begin
            next_st.settle = st.settle + 1'b1;
          end
          if (init_source == SRC_OSC) begin
            if (st.cnt >= CNT_W'(UM_CYC - 1)) begin
              next_st.state = S_USER;
            end
          end else if (st.cnt >= CNT_W'(INIT_CNT - 1) && init_tick) begin
            next_st.state = S_USER;
          end
        end
        S_USER: begin
          next_st.user_mode = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{state: S_RESET, req_s: 3'h7, default: '0};
      overflow <= 1'b0;
    end else begin
      st <= next_st;
      overflow <= st.bad;
    end
  end
  cfg_fifo #(.W(DATA_W), .D(8)) cfg_fifo_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (st.wdata),
    .in_valid  (st.wvalid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (word_ready)
  );
  assign word_data      = fifo_data;
  assign word_valid     = fifo_valid;
  assign link.status_o  = 1'b0;
  assign link.status_oe = st.status_low;
  assign link.done      = st.done;
  assign link.user_mode = st.user_mode;
endmodule

/* rtl/cfg_host.sv */
// host end: request pulse, status wait, data clocking
`timescale 1ns/1ps
module cfg_host
  import cfg_seq_pkg::*;
#(
  parameter int REQ_CYC  = CFG_LOW_CYC,
  parameter int WAIT_CYC = ST2CK_CYC,
  parameter int HALF_DIV = CLK_HALF_DIV
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  cfg_link_if.host               link,
  input  wire logic              start,
  input  wire logic [DATA_W-1:0] src_data,
  input  wire logic              src_valid,
  output logic                   src_ready,
  input  wire logic              hold_status_low,
  output logic                   busy,
  output logic                   loaded
);
  initial if (REQ_CYC < 1 || WAIT_CYC < 1 || HALF_DIV < 2) $error("host params");
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_REQ  = 5'h02,
    H_WAIT = 5'h04,
    H_SEND = 5'h08,
    H_DONE = 5'h10
  } host_e;
  typedef struct packed {
    host_e            state;
    logic [1:0]       stat_s;
    logic [1:0]       done_s;
    logic [1:0]       um_s;
    logic [CNT_W-1:0] cnt;
    logic             req_n;
    logic             cclk;
    logic [DATA_W-1:0] data;
    logic             have;
    logic             take;
    logic             busy;
    logic             loaded;
  } host_s;
  host_s st, next_st;
  always_comb begin
    next_st = st;
    next_st.stat_s = {st.stat_s[0], link.status_n};
    next_st.done_s = {st.done_s[0], link.done};
    next_st.um_s   = {st.um_s[0], link.user_mode};
    next_st.take = 1'b0;
    next_st.cnt = st.cnt + 1'b1;
    unique case (st.state)
      H_IDLE: begin
        if (start) begin
          next_st.state = H_REQ;
          next_st.req_n = 1'b0;
          next_st.cnt = '0;
          next_st.busy = 1'b1;
          next_st.loaded = 1'b0;
        end
      end
      H_REQ: begin
        if (st.cnt >= CNT_W'(REQ_CYC - 1) && !st.stat_s[1]) begin
          next_st.req_n = 1'b1;
          next_st.state = H_WAIT;
          next_st.cnt = '0;
        end
      end
      H_WAIT: begin
        if (!st.stat_s[1]) begin
          next_st.cnt = '0;
        end else if (st.cnt >= CNT_W'(WAIT_CYC - 1)) begin
          next_st.state = H_SEND;
          next_st.cnt = '0;
        end
      end
      H_SEND: begin
        if (st.cnt >= CNT_W'(HALF_DIV - 1)) begin
          next_st.cnt = '0;
          if (st.cclk) begin
            next_st.cclk = 1'b0;
            // clock runs on through initialization until user mode
            if (st.done_s[1]) begin
              if (st.um_s[1]) begin
                next_st.state = H_DONE;
              end
            end else if (src_valid) begin
              next_st.data = src_data;
              next_st.take = 1'b1;
              next_st.have = 1'b1;
            end else begin
              next_st.have = 1'b0;
            end
          end else if (st.have) begin
            next_st.cclk = 1'b1;
          end else if (src_valid) begin
            next_st.data = src_data;
            next_st.take = 1'b1;
            next_st.have = 1'b1;
          end
        end
      end
      H_DONE: begin
        next_st.busy = 1'b0;
        next_st.loaded = 1'b1;
        next_st.have = 1'b0;
        next_st.state = H_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{state: H_IDLE, req_n: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end
  assign src_ready           = next_st.take;
  assign busy                = st.busy;
  assign loaded              = st.loaded;
  assign link.request_n      = st.req_n;
  assign link.config_clock   = st.cclk;
  assign link.data           = st.data;
  assign link.status_ext_low = hold_status_low;
endmodule

/* tb/passive_config_sequencer_properties.sv */
// assertions on the link between the host and device ends
`timescale 1ns/1ps
module passive_config_sequencer_properties
  import cfg_seq_pkg::*;
#(
  parameter int STATUS_CYC = 10,
  parameter int WORDS      = 10,
  parameter int INIT_CNT   = 16
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       request_n,
  input wire logic       status_o,
  input wire logic       status_oe,
  input wire logic       status_ext_low,
  input wire logic       done,
  input wire logic       config_clock,
  input wire logic [7:0] data,
  input wire logic       user_mode,
  input wire logic       status_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  localparam int CD_MAX = CF2CD_CYC;
  localparam int S_MAX  = STATUS_CYC + 8;
  logic        cc_q;
  logic [7:0]  edges;
  logic [15:0] since;
  // rising config_clock edges per request, cycles since done
  always_ff @(posedge clk) begin
    cc_q <= config_clock;
    if (!rst_n || !request_n) edges <= 8'h00;
    else if (config_clock && !cc_q) edges <= edges + 8'h01;
    if (!done) since <= 16'h0000;
    else if (since != 16'hffff) since <= since + 16'h0001;
  end
  property p_done_fall; $fell(request_n) |-> ##[1:CD_MAX] !done; endproperty
  a_done_fall: assert property (p_done_fall) else $error("done still high");
  property p_status_fall; $fell(request_n) |-> ##[1:CD_MAX] status_oe; endproperty
  a_status_fall: assert property (p_status_fall) else $error("status not pulled");
  property p_req_width; $fell(request_n) |-> !request_n [*4]; endproperty
  a_req_width: assert property (p_req_width) else $error("request too short");
  property p_status_min; $rose(request_n) && status_oe |-> status_oe [*8]; endproperty
  a_status_min: assert property (p_status_min) else $error("status pulse short");
  property p_status_max;
    $rose(request_n) && !status_ext_low |-> ##[1:S_MAX] !status_oe;
  endproperty
  a_status_max: assert property (p_status_max) else $error("status not released");
  property p_clk_wait; $rose(status_n) |-> !config_clock [*4]; endproperty
  a_clk_wait: assert property (p_clk_wait) else $error("clock too early");
  property p_data_stable; $rose(config_clock) |-> $stable(data); endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved");
  property p_done_count; $rose(done) |-> edges >= WORDS && request_n; endproperty
  a_done_count: assert property (p_done_count) else $error("done too early");
  property p_init_len; $rose(user_mode) |-> done && since >= INIT_CNT; endproperty
  a_init_len: assert property (p_init_len) else $error("init too short");
  c_load: cover property ($rose(done));
  c_user: cover property ($rose(user_mode));
  c_hold: cover property (status_ext_low && $rose(request_n));
  c_reload: cover property ($fell(request_n) && done);
endmodule

/* tb/passive_config_sequencer_bench.sv */
// bench joining host and device ends across the link
`timescale 1ns/1ps
module passive_config_sequencer_bench
  import cfg_seq_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic              start;
  logic [DATA_W-1:0] src_data;
  logic              src_valid;
  logic              src_ready;
  logic              hold_status_low;
  logic              busy;
  logic              loaded;
  logic [1:0]        init_source;
  logic              user_clk_enable;
  logic              user_startup_clock;
  logic              ucg;
  logic [DATA_W-1:0] word_data;
  logic              word_valid;
  logic              word_ready;
  logic              overflow;
  int                n_fail;
  int                checks_done;
  int                sent;
  int                got;
  int                um;
  localparam int     UM = 20;
  localparam int     HOST_CYC = 4;
  localparam int     WORDS = 10;
  localparam int     ST_CYC = 10;
  localparam int     INIT_N = 16;
  cfg_link_if #(.W(DATA_W)) link ();
  cfg_host #(.REQ_CYC(HOST_CYC), .WAIT_CYC(HOST_CYC)) cfg_host_inst (
    .clk(clk), .rst_n(rst_n), .link(link), .start(start), .src_data(src_data),
    .src_valid(src_valid), .src_ready(src_ready), .hold_status_low(hold_status_low),
    .busy(busy), .loaded(loaded));
  cfg_device #(.STREAM_WORDS(WORDS), .STATUS_CYC(ST_CYC), .UM_CYC(UM), .INIT_CNT(INIT_N))
  cfg_device_inst (
    .clk(clk), .rst_n(rst_n), .link(link), .init_source(init_source),
    .user_clk_enable(user_clk_enable), .user_startup_clock(user_startup_clock),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
    .overflow(overflow));
  passive_config_sequencer_properties #(.STATUS_CYC(ST_CYC), .WORDS(WORDS), .INIT_CNT(INIT_N))
  check_inst (
    .clk(clk), .rst_n(rst_n), .request_n(link.request_n), .status_o(link.status_o),
    .status_oe(link.status_oe), .status_ext_low(link.status_ext_low), .done(link.done),
    .config_clock(link.config_clock), .data(link.data), .user_mode(link.user_mode),
    .status_n(link.status_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    user_startup_clock = 1'b0;
    forever #100 user_startup_clock = ucg & ~user_startup_clock;
  end
  always @(posedge clk) if (src_valid && src_ready) sent <= sent + 1;
  always @(negedge clk) src_data <= 8'ha5 ^ sent[7:0];
  always @(posedge clk) begin
    if (rst_n && word_valid && word_ready) begin
      check(word_data, 8'ha5 ^ got[7:0]);
      got <= got + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic reset_all();
    rst_n = 1'b0;
    start = 1'b0;
    src_data = 8'h00;
    src_valid = 1'b1;
    hold_status_low = 1'b0;
    init_source = SRC_OSC;
    user_clk_enable = 1'b0;
    word_ready = 1'b1;
    sent = 0;
    got = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
  endtask
  task automatic kick(input logic [1:0] src, input logic en);
    init_source = src;
    user_clk_enable = en;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask
  task automatic load(input logic [1:0] src, input logic en, input int hold);
    int n;
    reset_all();
    hold_status_low = (hold > 0);
    kick(src, en);
    repeat (hold) begin
      @(negedge clk);
      check(link.config_clock | link.status_n, 1'b0);
    end
    hold_status_low = 1'b0;
    n = 0;
    while (link.done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(link.done, 1'b1);
    um = 0;
    while (link.user_mode !== 1'b1 && um < 2000) begin
      @(negedge clk);
      um++;
    end
    check(link.user_mode, 1'b1);
    check(got, WORDS);
    check(word_valid, 1'b0);
    repeat (12) @(negedge clk);
    check(loaded, 1'b1);
    check(busy, 1'b0);
  endtask
  task automatic t_osc();
    load(SRC_OSC, 1'b0, 0);
    check(um >= UM - 1 && um <= UM * CD2UM_MAX_US / CD2UM_MIN_US + 1, 1'b1);
  endtask
  task automatic t_user();
    ucg = 1'b1;
    load(SRC_USER, 1'b1, 0);
    check(um >= CD2CU_PERIODS * 2 * CLK_HALF_DIV + (INIT_N - 1) * 8, 1'b1);
  endtask
  task automatic t_fallback();
    ucg = 1'b0;
    load(SRC_USER, 1'b0, 0);
  endtask
  task automatic t_overflow();
    reset_all();
    word_ready = 1'b0;
    kick(SRC_OSC, 1'b0);
    repeat (200) @(negedge clk);
    check(overflow, 1'b1);
    check(link.done, 1'b0);
    check(busy, 1'b1);
    src_valid = 1'b0;
    repeat (20) @(negedge clk);
    word_ready = 1'b1;
    repeat (20) @(negedge clk);
    check(word_valid, 1'b0);
    check(got, 8);
  endtask
  task automatic t_reload();
    int g0;
    int n;
    got = sent;
    g0 = sent;
    kick(SRC_CCLK, 1'b0);
    repeat (4) @(negedge clk);
    check(link.done, 1'b0);
    check(link.status_n, 1'b0);
    n = 0;
    while (link.user_mode !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(link.user_mode, 1'b1);
    check(got - g0, WORDS);
  endtask
  initial begin
    n_fail = 0;
    checks_done = 0;
    ucg = 1'b0;
    t_osc();
    load(SRC_OSC, 1'b0, 60);
    t_user();
    t_fallback();
    load(SRC_CCLK, 1'b0, 0);
    t_reload();
    t_overflow();
    finish_test();
  end
  initial begin
    #500000;
    n_fail++;
    finish_test();
  end
endmodule
